// ===== design/dsw_pkg.sv
/*
  Package for the distance switch output logic: register map, reset values,
  modes, analog spans and range limits.
  Assumes distances arrive as unsigned counts of 0.1 mm.
*/
package dsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_ANA_MIN  = 12'h004;
  localparam logic [11:0] OFS_ANA_MAX  = 12'h008;
  localparam logic [11:0] OFS_STATUS   = 12'h00c;
  localparam logic [11:0] OFS_CH_BASE  = 12'h010;
  localparam logic [11:0] OFS_CH_STEP  = 12'h010;
  localparam logic [1:0]  FLD_FAR      = 2'h0;
  localparam logic [1:0]  FLD_NEAR     = 2'h1;
  localparam logic [1:0]  FLD_HYST     = 2'h2;
  localparam logic [1:0]  FLD_RESV     = 2'h3;

  // Control register field positions
  localparam int CTRL_SPAN_LSB = 0;
  localparam int CTRL_FALL     = 2;
  localparam int CTRL_DARK_LSB = 3;
  localparam int CTRL_MODE_LSB = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and spans
  typedef enum logic [1:0] {
    SINGLE_POINT_OBJECT_MODE,
    WINDOW_MODE,
    DUAL_SETPOINT_MODE,
    SINGLE_POINT_BACKGROUND_MODE
  } dsw_mode_type;

  typedef enum logic [1:0] {
    SPAN_CUR_4_20,
    SPAN_VOLT_1_10,
    SPAN_VOLT_0_10
  } dsw_span_type;

  // Analog endpoints in uA for current, mV for voltage
  localparam logic [15:0] CUR_LO  = 16'h0fa0;
  localparam logic [15:0] CUR_HI  = 16'h4e20;
  localparam logic [15:0] V110_LO = 16'h03e8;
  localparam logic [15:0] V110_HI = 16'h2710;
  localparam logic [15:0] V010_LO = 16'h0000;
  localparam logic [15:0] V010_HI = 16'h2710;

  ////////////////////////////////////////////////////////////////////////////
  // Range limits and reset values (0.1 mm units), division step count
  localparam logic [15:0] RANGE_MIN    = 16'h01f4;
  localparam logic [15:0] RANGE_MAX    = 16'h03e8;
  localparam logic [15:0] RST_FAR      = 16'h03e8;
  localparam logic [15:0] RST_NEAR     = 16'h01f4;
  localparam logic [15:0] RST_HYST     = 16'h000a;
  localparam logic [15:0] RST_RESV     = 16'h0000;
  localparam int          DIV_STEPS    = 32;

endpackage : dsw_pkg

// ===== design/dsw_ch_if.sv
/*
  Interface carrying one switching channel's settings and its output.
  Assumes the top drives settings and the evaluator drives the output.
*/
`timescale 1ns/1ns
`default_nettype none
interface dsw_ch_if;
  import dsw_pkg::*;
  logic [15:0]  far_setpoint;
  logic [15:0]  near_setpoint;
  logic [15:0]  hyst;
  logic [15:0]  resv;
  dsw_mode_type mode;
  logic         dark;
  logic         enable;
  logic         out;
  modport cfg  (output far_setpoint, near_setpoint, hyst, resv, mode, dark, enable,
                input out);
  modport eval (input far_setpoint, near_setpoint, hyst, resv, mode, dark, enable,
                output out);
endinterface : dsw_ch_if
`default_nettype wire

// ===== design/dsw_switch.sv
/*
  One switching channel: edge placement per mode, hysteresis and logic.
  Assumes meas_strobe is a one-cycle pulse per completed measurement.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_switch
  import dsw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        meas_strobe,
  input  wire logic        meas_valid,
  input  wire logic [15:0] meas_dist,
  dsw_ch_if.eval           ch
);

  logic               act_r;
  logic               act_nxt;
  logic               out_r;
  logic signed [17:0] d;
  logic signed [17:0] lim;
  logic signed [17:0] far_s;
  logic signed [17:0] near_s;
  logic signed [17:0] hy;
  logic signed [17:0] rs;
  logic signed [17:0] near_e;
  logic signed [17:0] far_e;
  logic signed [17:0] on_lo;
  logic signed [17:0] on_hi;
  logic signed [17:0] off_lo;
  logic signed [17:0] off_hi;
  logic               in_on;
  logic               in_off;

  ////////////////////////////////////////////////////////////////////////////
  // Edge placement
  assign d      = {2'b00, meas_dist};
  assign lim    = {2'b00, RANGE_MIN};
  assign far_s  = {2'b00, ch.far_setpoint};
  assign near_s = {2'b00, ch.near_setpoint};
  assign hy     = {2'b00, ch.hyst};
  assign rs     = {2'b00, ch.resv};
  assign near_e = (near_s < lim + hy) ? near_s + hy : near_s;
  assign far_e  = (far_s < near_e) ? near_e : far_s;

  always_comb begin
    on_lo  = lim;
    off_lo = lim - hy;
    on_hi  = far_s + rs;
    off_hi = far_s + rs + hy;
    case (ch.mode)
      SINGLE_POINT_OBJECT_MODE: begin
        on_hi  = far_s + rs;
        off_hi = far_s + rs + hy;
      end
      WINDOW_MODE: begin
        on_lo  = near_s;
        off_lo = near_s - hy;
        on_hi  = far_s;
        off_hi = far_s + hy;
      end
      DUAL_SETPOINT_MODE: begin
        on_hi  = near_e - 18'sd1;
        off_hi = far_e;
      end
      SINGLE_POINT_BACKGROUND_MODE: begin
        on_hi  = far_s - rs - hy - 18'sd1;
        off_hi = far_s - rs - 18'sd1;
      end
      default: begin
        on_hi  = far_s;
        off_hi = far_s;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hysteresis state
  assign in_on  = (d >= on_lo) && (d <= on_hi);
  assign in_off = (d < off_lo) || (d > off_hi);

  always_comb begin
    act_nxt = act_r;
    if (!ch.enable || !meas_valid) begin
      act_nxt = 1'b0;
    end else if (in_on) begin
      act_nxt = 1'b1;
    end else if (in_off) begin
      act_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      act_r <= 1'b0;
      out_r <= 1'b0;
    end else if (meas_strobe) begin
      act_r <= act_nxt;
      out_r <= ch.enable & (ch.dark ^ act_nxt);
    end
  end

  assign ch.out = out_r;

endmodule : dsw_switch
`default_nettype wire

// ===== design/dsw_top.sv
/*
  Distance switch output logic: APB register file, two switching channels
  and the linear analog output value.
  Assumes one 50 MHz clock, APB master, distance in 0.1 mm counts.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_top
  import dsw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        meas_strobe,
  input  wire logic        meas_valid,
  input  wire logic [15:0] meas_dist,
  input  wire logic        variant_two_out,
  input  wire logic        variant_mfi,
  output logic             switch_channel_one,
  output logic             switch_channel_two,
  output logic      [15:0] analog_value,
  output logic      [1:0]  analog_span
);

  typedef enum logic [1:0] {ANA_IDLE, ANA_PREP, ANA_DIV} dsw_ana_type;

  logic [1:0]   span_r;
  logic         fall_r;
  logic [1:0]   dark_r;
  dsw_mode_type mode_r [0:1];
  logic [15:0]  ana_min_r;
  logic [15:0]  ana_max_r;
  logic [15:0]  far_r  [0:1];
  logic [15:0]  near_r [0:1];
  logic [15:0]  hyst_r [0:1];
  logic [15:0]  resv_r [0:1];
  logic         two_r;
  logic         mfi_r;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  logic [15:0]  dist_r;
  logic         valid_r;
  logic [1:0]   ch_out;
  logic [1:0]   ch_en;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic        setup;
  logic        wr_acc;
  logic        sel_ctrl;
  logic        sel_amin;
  logic        sel_amax;
  logic        sel_stat;
  logic [1:0]  sel_ch;
  logic [1:0]  fld;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [15:0] ch_rd [0:1];

  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign sel_ctrl = paddr == OFS_CTRL;
  assign sel_amin = paddr == OFS_ANA_MIN;
  assign sel_amax = paddr == OFS_ANA_MAX;
  assign sel_stat = paddr == OFS_STATUS;
  assign fld      = paddr[3:2];
  assign sel_ch[0] = (paddr[11:4] == OFS_CH_BASE[11:4]) && (paddr[1:0] == 2'b00);
  assign sel_ch[1] = (paddr[11:4] == OFS_CH_BASE[11:4] + OFS_CH_STEP[11:4])
                     && (paddr[1:0] == 2'b00);
  assign mapped   = sel_ctrl | sel_amin | sel_amax | sel_stat | (|sel_ch);

  assign rd_mux = sel_ctrl ? {23'h000000, mode_r[1], mode_r[0], dark_r, fall_r, span_r} :
                  sel_amin ? {16'h0000, ana_min_r} :
                  sel_amax ? {16'h0000, ana_max_r} :
                  sel_stat ? {ch_out, valid_r, 13'h0000, dist_r} :
                  sel_ch[0] ? {16'h0000, ch_rd[0]} :
                  sel_ch[1] ? {16'h0000, ch_rd[1]} : 32'h00000000;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      span_r    <= SPAN_CUR_4_20;
      fall_r    <= 1'b0;
      dark_r    <= 2'b00;
      ana_min_r <= RANGE_MIN;
      ana_max_r <= RANGE_MAX;
    end else if (wr_acc) begin
      if (sel_ctrl) begin
        span_r <= pwdata[CTRL_SPAN_LSB +: 2];
        fall_r <= pwdata[CTRL_FALL];
        dark_r <= pwdata[CTRL_DARK_LSB +: 2];
      end
      if (sel_amin) begin
        ana_min_r <= pwdata[15:0];
      end
      if (sel_amax) begin
        ana_max_r <= pwdata[15:0];
      end
    end
  end

  // Variant straps, sampled on every clock after reset release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      two_r <= 1'b0;
      mfi_r <= 1'b0;
    end else begin
      two_r <= variant_two_out;
      mfi_r <= variant_mfi;
    end
  end

  assign ch_en[0] = 1'b1;
  assign ch_en[1] = two_r & ~mfi_r;

  ////////////////////////////////////////////////////////////////////////////
  // Switching channels
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      dsw_ch_if chi ();

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          mode_r[c] <= SINGLE_POINT_OBJECT_MODE;
          far_r[c]  <= RST_FAR;
          near_r[c] <= RST_NEAR;
          hyst_r[c] <= RST_HYST;
          resv_r[c] <= RST_RESV;
        end else if (wr_acc) begin
          if (sel_ctrl) begin
            mode_r[c] <= dsw_mode_type'(pwdata[CTRL_MODE_LSB + 2*c +: 2]);
          end
          if (sel_ch[c] && fld == FLD_FAR) begin
            far_r[c] <= pwdata[15:0];
          end
          if (sel_ch[c] && fld == FLD_NEAR) begin
            near_r[c] <= pwdata[15:0];
          end
          if (sel_ch[c] && fld == FLD_HYST) begin
            hyst_r[c] <= pwdata[15:0];
          end
          if (sel_ch[c] && fld == FLD_RESV) begin
            resv_r[c] <= pwdata[15:0];
          end
        end
      end

      assign ch_rd[c] = (fld == FLD_FAR)  ? far_r[c] :
                        (fld == FLD_NEAR) ? near_r[c] :
                        (fld == FLD_HYST) ? hyst_r[c] : resv_r[c];

      assign chi.far_setpoint  = far_r[c];
      assign chi.near_setpoint = near_r[c];
      assign chi.hyst          = hyst_r[c];
      assign chi.resv          = resv_r[c];
      assign chi.mode          = mode_r[c];
      assign chi.dark          = dark_r[c];
      assign chi.enable        = ch_en[c];
      assign ch_out[c]         = chi.out;

      dsw_switch u_sw (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .meas_strobe (meas_strobe),
        .meas_valid  (meas_valid),
        .meas_dist   (meas_dist),
        .ch          (chi.eval)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Analog value: lo + (hi - lo) * n / (max - min), by serial division
  dsw_ana_type ana_st_r;
  logic [5:0]  step_r;
  logic [31:0] quo_r;
  logic [16:0] rem_r;
  logic [15:0] den_r;
  logic [15:0] lo_r;
  logic [15:0] analog_r;
  logic [15:0] span_lo;
  logic [15:0] span_hi;
  logic [15:0] dclamp;
  logic [15:0] num;
  logic [31:0] prod;
  logic [16:0] rshift;
  logic        rge;

  assign span_lo = (span_r == SPAN_VOLT_1_10) ? V110_LO :
                   (span_r == SPAN_VOLT_0_10) ? V010_LO : CUR_LO;
  assign span_hi = (span_r == SPAN_VOLT_1_10) ? V110_HI :
                   (span_r == SPAN_VOLT_0_10) ? V010_HI : CUR_HI;
  assign dclamp  = (dist_r < ana_min_r) ? ana_min_r :
                   (dist_r > ana_max_r) ? ana_max_r : dist_r;
  assign num     = fall_r ? ana_max_r - dclamp : dclamp - ana_min_r;
  assign prod    = num * (span_hi - span_lo);
  assign rshift  = {rem_r[15:0], quo_r[31]};
  assign rge     = rshift >= {1'b0, den_r};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dist_r  <= 16'h0000;
      valid_r <= 1'b0;
    end else if (meas_strobe) begin
      valid_r <= meas_valid;
      if (meas_valid) begin
        dist_r <= meas_dist;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ana_st_r <= ANA_IDLE;
      step_r   <= 6'h00;
      quo_r    <= 32'h00000000;
      rem_r    <= 17'h00000;
      den_r    <= 16'h0000;
      lo_r     <= CUR_LO;
      analog_r <= CUR_LO;
    end else begin
      case (ana_st_r)
        ANA_IDLE: begin
          if (meas_strobe && meas_valid) begin
            ana_st_r <= ANA_PREP;
          end
        end
        ANA_PREP: begin
          den_r    <= ana_max_r - ana_min_r;
          quo_r    <= prod;
          rem_r    <= 17'h00000;
          lo_r     <= span_lo;
          step_r   <= 6'h00;
          ana_st_r <= (ana_max_r > ana_min_r) ? ANA_DIV : ANA_IDLE;
          if (ana_max_r <= ana_min_r) begin
            analog_r <= span_lo;
          end
        end
        ANA_DIV: begin
          rem_r  <= rge ? rshift - {1'b0, den_r} : rshift;
          quo_r  <= {quo_r[30:0], rge};
          step_r <= step_r + 6'h01;
          if (step_r == 6'(DIV_STEPS - 1)) begin
            analog_r <= lo_r + {quo_r[14:0], rge};
            ana_st_r <= ANA_IDLE;
          end
        end
        default: ana_st_r <= ANA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign switch_channel_one = ch_out[0];
  assign switch_channel_two = ch_out[1];
  assign analog_value       = analog_r;
  assign analog_span        = span_r;

endmodule : dsw_top
`default_nettype wire

// ===== verif/dsw_chk.sv
/*
  Checker for dsw_top: bus timing, pin holding, channel two, analog timing.
  Assumes it is bound to dsw_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        meas_strobe,
  input wire logic        meas_valid,
  input wire logic        variant_two_out,
  input wire logic        variant_mfi,
  input wire logic        switch_channel_one,
  input wire logic        switch_channel_two,
  input wire logic [15:0] analog_value,
  input wire logic [1:0]  analog_span
);
  logic [8:0] ctrl_r;
  wire        ctrl_wr = psel & penable & pready & pwrite & ~pslverr & (paddr == 12'h000);
  wire        vld_str = meas_strobe & meas_valid;

  // Shadow of the control word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) ctrl_r <= 9'h000;
    else if (ctrl_wr) ctrl_r <= pwdata[8:0];
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence setup_s; psel && !penable; endsequence
  sequence quiet_s; !meas_strobe && !psel; endsequence
  sequence no_wr_s; !ctrl_wr [*2]; endsequence

  ready_after_a: assert property (setup_s |=> pready) else $error("no pready after setup");
  ready_once_a: assert property (pready |-> penable && $past(psel) && !$past(penable))
    else $error("pready outside access");
  bad_addr_a: assert property (psel && !penable && (paddr > 12'h02c || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("no error on bad address");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not idle");
  pin_hold_a: assert property (
    quiet_s ##1 quiet_s |=> $stable(switch_channel_one)) else $error("pin moved unprompted");
  invalid_off_a: assert property (
    meas_strobe && !meas_valid |=> switch_channel_one == ctrl_r[3]) else $error("not inactive");
  ch2_off_a: assert property (
    (!variant_two_out || variant_mfi) [*4] |-> !switch_channel_two) else $error("ch2 not off");
  span_now_a: assert property (no_wr_s |-> analog_span == ctrl_r[1:0])
    else $error("span differs from control");
  ana_time_a: assert property (
    $changed(analog_value) |-> $past(vld_str, 34) || $past(vld_str, 2))
    else $error("analog changed off schedule");
endmodule : dsw_chk

bind dsw_top dsw_chk dsw_chk_i (.sys_clk(sys_clk), .reset(reset), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .meas_strobe(meas_strobe), .meas_valid(meas_valid),
  .variant_two_out(variant_two_out), .variant_mfi(variant_mfi),
  .switch_channel_one(switch_channel_one), .switch_channel_two(switch_channel_two),
  .analog_value(analog_value), .analog_span(analog_span));
`default_nettype wire

// ===== verif/dsw_plc_model.sv
/*
  Controller model: reads both switching inputs and the analog input.
  Assumes the levels come straight from the block's outputs.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_plc_model (
  input  wire logic        in_one,
  input  wire logic        in_two,
  input  wire logic [15:0] in_analog,
  output logic             seen_one,
  output logic             seen_two,
  output logic      [15:0] seen_analog
);
  // Input card passes levels through; the controller only reads
  assign seen_one    = in_one;
  assign seen_two    = in_two;
  assign seen_analog = in_analog;
endmodule : dsw_plc_model
`default_nettype wire

// ===== verif/tb_dsw_top.sv
/*
  Testbench for dsw_top: register map, switching modes, variants, analog value.
  Assumes dsw_pkg, dsw_top, dsw_chk and dsw_plc_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_dsw_top;
  import dsw_pkg::*;
  logic        sys_clk         = 1'b0;
  logic        reset           = 1'b1;
  logic [11:0] paddr           = 12'h000;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [31:0] pwdata          = 32'h0;
  logic        meas_strobe     = 1'b0;
  logic        meas_valid      = 1'b0;
  logic [15:0] meas_dist       = 16'h0;
  logic        variant_two_out = 1'b1;
  logic        variant_mfi     = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, sw_one, sw_two, seen_one, seen_two;
  wire  [15:0] ana, seen_ana;
  wire  [1:0]  span;
  logic [15:0] cfg [2][4];
  logic [8:0]  ctrl = 9'h0;
  logic        act [2] = '{1'b0, 1'b0};
  logic        en2 = 1'b1;
  logic        str_d = 1'b0;
  int          amin = 500, amax = 1000, acnt = 0, cyc = 0, fails = 0, comparisons = 0;
  logic [32:0] bus_q [$];
  logic [1:0]  pin_q [$];
  logic [15:0] ana_q [$];
  int          dl [] = '{500, 495, 0, 495, 600, 800, 805, 806, 816, 817, 830, 816, 806, 780,
                         505, 512, 513, 516, 490, 489, 2000};
  int          al [5] = '{550, 600, 750, 900, 950};
  logic [15:0] cv [8] = '{800, 600, 10, 5, 505, 502, 10, 0};
  logic [31:0] rst_tab [12] = '{0, 500, 1000, 0, 1000, 500, 10, 0, 1000, 500, 10, 0};

  dsw_top dsw_top_i (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_strobe(meas_strobe), .meas_valid(meas_valid),
    .meas_dist(meas_dist), .variant_two_out(variant_two_out), .variant_mfi(variant_mfi),
    .switch_channel_one(sw_one), .switch_channel_two(sw_two), .analog_value(ana),
    .analog_span(span));
  dsw_plc_model dsw_plc_model_i (.in_one(sw_one), .in_two(sw_two), .in_analog(ana),
    .seen_one(seen_one), .seen_two(seen_two), .seen_analog(seen_ana));

  initial forever #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    bus_q.push_back(e);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    if (a == 12'h000) ctrl = d[8:0];
    else if (a == 12'h004) amin = d;
    else if (a == 12'h008) amax = d;
    else cfg[a[5]][a[3:2]] = d;
    apb(a, 1'b1, {(a < 12'h010) ? 16'h0 : 16'($urandom), d}, 33'h0);
  endtask : wr

  // Expected activity of one channel for one valid distance
  function automatic logic nxt(input int c, input int d);
    int f, n, h, r, lo, on_hi, off_hi, ne, m;
    f      = cfg[c][0];
    n      = cfg[c][1];
    h      = cfg[c][2];
    r      = cfg[c][3];
    m      = c ? ctrl[8:7] : ctrl[6:5];
    ne     = (n < 500 + h) ? n + h : n;
    lo     = (m == 1) ? n : 500;
    on_hi  = m == 0 ? f + r : m == 1 ? f : m == 2 ? ne - 1 : f - r - h - 1;
    off_hi = m == 0 ? f + r + h : m == 1 ? f + h : m == 2 ? (f > ne ? f : ne) : f - r - 1;
    if (d >= lo && d <= on_hi) return 1'b1;
    if (d < lo - h || d > off_hi) return 1'b0;
    return act[c];
  endfunction : nxt

  task automatic meas(input int d, input logic v);
    int lo, hi, n;
    for (int c = 0; c < 2; c++) act[c] = v && nxt(c, d);
    pin_q.push_back({en2 & (ctrl[4] ^ act[1]), ctrl[3] ^ act[0]});
    if (v) begin
      lo = ctrl[1:0] == 2'h1 ? V110_LO : ctrl[1:0] == 2'h2 ? V010_LO : CUR_LO;
      hi = ctrl[1:0] == 2'h1 ? V110_HI : ctrl[1:0] == 2'h2 ? V010_HI : CUR_HI;
      n  = d < amin ? amin : d > amax ? amax : d;
      n  = ctrl[2] ? amax - n : n - amin;
      ana_q.push_back(16'(amax <= amin ? lo : lo + (hi - lo) * n / (amax - amin)));
    end
    meas_dist   <= 16'(d);
    meas_valid  <= v;
    meas_strobe <= 1'b1;
    @(posedge sys_clk) meas_strobe <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask : meas

  ////////////////////////////////////////////////////////////
  // Output watcher: oldest note against each result
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 30000) begin
      fails++;
      print_verdict();
    end
    if (psel && penable && pready) chk("bus", bus_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    if (str_d) chk("pins", 33'(pin_q.pop_front()), {31'h0, seen_two, seen_one});
    if (acnt == 1) chk("analog", 33'(ana_q.pop_front()), {17'h0, seen_ana});
    acnt  = (meas_strobe && meas_valid) ? 36 : (acnt > 0 ? acnt - 1 : 0);
    str_d = meas_strobe;
  end

  initial begin
    void'($urandom(37220));
    for (int i = 0; i < 8; i++) cfg[i / 4][i % 4] = rst_tab[4 + i][15:0];
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    apb(12'h030, 1'b0, 32'h0, {1'b1, 32'h0});
    apb(12'h012, 1'b1, 32'h5, {1'b1, 32'h0});
    apb(12'h00c, 1'b1, 32'hffff_ffff, 33'h0);
    foreach (rst_tab[i]) apb(12'(i * 4), 1'b0, 32'h0, {1'b0, rst_tab[i]});
    for (int i = 0; i < 8; i++) wr(12'(16 + 4 * i), cv[i]);
    apb(12'h014, 1'b0, 32'h0, {1'b0, 32'd600});
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        wr(12'h000, 16'({m[1:0] ^ 2'h1, m[1:0], ~k[0], k[0], 3'h0}));
        foreach (dl[j]) meas(dl[j], dl[j] != 0);
        repeat (10) meas(470 + $urandom % 400, $urandom % 8 != 0);
      end
    end
    wr(12'h000, 16'h0010);
    variant_two_out <= 1'b0;
    en2 = 1'b0;
    repeat (3) @(posedge sys_clk);
    meas(600, 1'b1);
    variant_two_out <= 1'b1;
    variant_mfi     <= 1'b1;
    repeat (3) @(posedge sys_clk);
    meas(600, 1'b1);
    variant_mfi <= 1'b0;
    en2 = 1'b1;
    repeat (3) @(posedge sys_clk);
    meas(600, 1'b1);
    wr(12'h004, 16'd600);
    wr(12'h008, 16'd900);
    for (int s = 0; s < 6; s++) begin
      wr(12'h000, 16'(s / 3 * 4 + s % 3));
      foreach (al[j]) meas(al[j], 1'b1);
      meas(600 + $urandom % 301, 1'b1);
    end
    wr(12'h008, 16'd600);
    meas(700, 1'b1);
    print_verdict();
  end
endmodule : tb_dsw_top
`default_nettype wire
